// ==== core/edge_delay_if.sv ====
// Connection between the gate control logic and its edge delay timer.
`timescale 1ns/1ps
`default_nettype none
interface edge_delay_if;
  import rail_gate_pkg::*;

  logic        request;
  delay_code_t rise_code;
  delay_code_t fall_code;
  logic        delayed;
  logic        timing;

  modport ctrl  (output request, output rise_code, output fall_code,
                 input delayed, input timing);
  modport timer (input request, input rise_code, input fall_code,
                 output delayed, output timing);
endinterface
`default_nettype wire

// ==== core/edge_delay_timer.sv ====
// Delays the rising and falling edges of the enable request by coded times.
`timescale 1ns/1ps
`default_nettype none
`include "rail_gate_defs.svh"
module edge_delay_timer #(
  parameter int MS_CYCLES = `MS_CYCLES
) (
  input wire logic    clk_sys,
  input wire logic    reset_n,
  edge_delay_if.timer dly
);
  import rail_gate_pkg::*;

  timer_state_t state_q;
  logic         delayed_q;
  logic [31:0]  pre_q;
  delay_ms_t    ms_q;
  delay_ms_t    target_q;
  logic         ms_tick;
  logic         differ;
  delay_code_t  code_now;

  // Converts a delay code to whole milliseconds.
  function automatic delay_ms_t code_to_ms(input delay_code_t code);
    case (code)
      3'h1:    code_to_ms = `DLY_MS_CODE1;
      3'h2:    code_to_ms = `DLY_MS_CODE2;
      3'h3:    code_to_ms = `DLY_MS_CODE3;
      3'h4:    code_to_ms = `DLY_MS_CODE4;
      3'h5:    code_to_ms = `DLY_MS_CODE5;
      3'h6:    code_to_ms = `DLY_MS_CODE6;
      3'h7:    code_to_ms = `DLY_MS_CODE7;
      default: code_to_ms = 7'h00;
    endcase
  endfunction

  // The pending edge and the code that governs it.
  assign differ   = dly.request != delayed_q;
  assign code_now = dly.request ? dly.rise_code : dly.fall_code;
  assign ms_tick  = (pre_q == 32'(MS_CYCLES - 1));

  // Sequencing of a pending edge; a request that reverts in time cancels it.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      state_q <= TMR_STABLE;
    else
      case (state_q)
        TMR_STABLE:
        begin
          if (differ && code_now != 3'h0)
            state_q <= dly.request ? TMR_RISE_WAIT : TMR_FALL_WAIT;
        end
        TMR_RISE_WAIT, TMR_FALL_WAIT:
        begin
          if (!differ || (ms_tick && ms_q + 7'h01 == target_q))
            state_q <= TMR_STABLE;
        end
        default: state_q <= TMR_STABLE;
      endcase
  end

  // The delayed request follows at once for code zero, else at expiry.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      delayed_q <= 1'b0;
    else if (state_q == TMR_STABLE && differ && code_now == 3'h0)
      delayed_q <= dly.request; // R9 R10
    else if (state_q != TMR_STABLE && differ && ms_tick && ms_q + 7'h01 == target_q)
      delayed_q <= dly.request; // R9 R10
  end

  // Millisecond divider, restarted when an edge starts its wait.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || state_q == TMR_STABLE || ms_tick)
      pre_q <= 32'h0000_0000;
    else
      pre_q <= pre_q + 32'h0000_0001;
  end

  // Millisecond count and the target latched at the start of a wait.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      ms_q     <= 7'h00;
      target_q <= 7'h00;
    end
    else if (state_q == TMR_STABLE)
    begin
      ms_q     <= 7'h00;
      target_q <= code_to_ms(code_now); // R9 R10
    end
    else if (ms_tick)
      ms_q <= ms_q + 7'h01;
  end

  assign dly.delayed = delayed_q;
  assign dly.timing  = state_q != TMR_STABLE;

endmodule
`default_nettype wire

// ==== core/rail_enable_gating_logic.sv ====
// Enable gating for the controlled converter rail: registers, source select and power-good gate.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "rail_gate_defs.svh"

// How it works
// R1 - Mask bit zero includes power-good, one ignores.
// R2 - Bits 7-5 mask aux three, two, switch A1.
// R3 - Bits 4-0 mask rails six, five, four, three, one.
// R4 - Second register bits 1-0 mask B2/reg1, B1.
// R5 - Step bit picks 10 mV or 25 mV.
// R6 - Software leaves step bit alone at run time.
// R7 - Source field routes the chosen control input.
// R8 - Source code 111 feeds constant one.
// R9 - Falling edge delayed by coded time.
// R10 - Rising edge delayed by same table.
// R11 - Rail on: delayed request and unmasked power-goods.
module rail_enable_gating_logic #(
  parameter int MS_CYCLES = `MS_CYCLES
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  // Register port.
  input  wire logic [7:0]               reg_addr,
  input  wire rail_gate_pkg::reg_byte_t reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output var  rail_gate_pkg::reg_byte_t reg_rdata,
  // Control input pins.
  input  wire logic                     control_input_one,
  input  wire logic                     control_input_two,
  input  wire logic                     control_input_three,
  input  wire logic                     control_input_four,
  input  wire logic                     control_input_five,
  input  wire logic                     control_input_six,
  // Power-good signals of the other rails.
  input  wire logic                     converter_rail_one_power_good,
  input  wire logic                     converter_rail_three_power_good,
  input  wire logic                     converter_rail_four_power_good,
  input  wire logic                     converter_rail_five_power_good,
  input  wire logic                     converter_rail_six_power_good,
  input  wire logic                     load_switch_a_one_power_good,
  input  wire logic                     aux_regulator_two_power_good,
  input  wire logic                     aux_regulator_three_power_good,
  input  wire logic                     load_switch_b_one_power_good,
  input  wire logic                     switch_b_two_regulator_one_power_good,
  // Outputs to the converter.
  output var  logic                     controlled_converter_rail_enable,
  output var  logic                     voltage_increment_select
);
  import rail_gate_pkg::*;

  localparam int PG_COUNT = 10;

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------

  reg_byte_t pg_mask_a_q;
  reg_byte_t source_step_q;
  reg_byte_t enable_delays_q;
  reg_byte_t rdata_q;

  // ---------------------------------------------------------------
  // Gate signals
  // ---------------------------------------------------------------

  logic [PG_COUNT-1:0] pg_in;
  logic [PG_COUNT-1:0] pg_mask;
  logic [PG_COUNT-1:0] pg_pass;
  logic                pg_all_ok;
  logic [2:0]          source_sel;
  logic                selected_req;
  logic                rail_on_q;
  logic                step_q;

  edge_delay_if dly ();

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------

  // Mask register for the auxiliary, switch and converter rails.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      pg_mask_a_q <= `RST_PG_MASK_A;
    else if (reg_wr && reg_addr == `OFF_PG_MASK_A)
      pg_mask_a_q <= reg_wdata;
  end

  // Source, step and the two load switch masks.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      source_step_q <= `RST_SOURCE_AND_STEP;
    else if (reg_wr && reg_addr == `OFF_SOURCE_AND_STEP)
      source_step_q <= reg_wdata;
  end

  // Falling and rising edge delay codes.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      enable_delays_q <= `RST_ENABLE_DELAYS;
    else if (reg_wr && reg_addr == `OFF_ENABLE_DELAYS)
      enable_delays_q <= reg_wdata;
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------

  // Read data stands in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      rdata_q <= 8'h00;
    else if (reg_rd)
      case (reg_addr)
        `OFF_PG_MASK_A:       rdata_q <= pg_mask_a_q;
        `OFF_SOURCE_AND_STEP: rdata_q <= source_step_q;
        `OFF_ENABLE_DELAYS:   rdata_q <= enable_delays_q;
        `OFF_GATE_STATUS:
        begin
          rdata_q                       <= 8'h00;
          rdata_q[`POS_ST_RAIL_ON]      <= rail_on_q;
          rdata_q[`POS_ST_DELAYED_REQ]  <= dly.delayed;
          rdata_q[`POS_ST_SELECTED_REQ] <= selected_req;
          rdata_q[`POS_ST_PG_OK]        <= pg_all_ok;
          rdata_q[`POS_ST_TIMING]       <= dly.timing;
        end
        default:              rdata_q <= 8'h00;
      endcase
    else
      rdata_q <= 8'h00;
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // Enable source selection
  // ---------------------------------------------------------------

  assign source_sel = source_step_q[`POS_SOURCE_HI:`POS_SOURCE_LO];

  // Routes the chosen control input, or a constant one, as the request.
  always_comb
  begin
    case (source_sel)
      `SRC_INPUT_ONE:         selected_req = control_input_one; // R7
      `SRC_INPUT_TWO:         selected_req = control_input_two; // R7
      `SRC_INPUT_FIVE:        selected_req = control_input_five; // R7
      `SRC_INPUT_FOUR:        selected_req = control_input_four; // R7
      `SRC_INPUT_THREE:       selected_req = control_input_three; // R7
      `SRC_INPUTS_THREE_FOUR: selected_req = control_input_three & control_input_four; // R7
      `SRC_INPUT_SIX:         selected_req = control_input_six; // R7
      `SRC_ALWAYS_ON:         selected_req = 1'b1; // R8
      default:                selected_req = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Edge delays
  // ---------------------------------------------------------------

  // The timer holds the request back by the coded rising or falling time.
  assign dly.request   = selected_req;
  assign dly.rise_code = enable_delays_q[`POS_RISE_HI:`POS_RISE_LO]; // R10
  assign dly.fall_code = enable_delays_q[`POS_FALL_HI:`POS_FALL_LO]; // R9

  edge_delay_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .dly     (dly.timer)
  );

  // ---------------------------------------------------------------
  // Power-good gate
  // ---------------------------------------------------------------

  // Power-good inputs in the order of their mask bits.
  assign pg_in = {switch_b_two_regulator_one_power_good, // R4
                  load_switch_b_one_power_good, // R4
                  aux_regulator_three_power_good, // R2
                  aux_regulator_two_power_good, // R2
                  load_switch_a_one_power_good, // R2
                  converter_rail_six_power_good, // R3
                  converter_rail_five_power_good, // R3
                  converter_rail_four_power_good, // R3
                  converter_rail_three_power_good, // R3
                  converter_rail_one_power_good}; // R3

  // Mask bits from both registers lined up with the inputs above.
  assign pg_mask = {source_step_q[`POS_MASK_SWB2_REG1], // R4
                    source_step_q[`POS_MASK_LOAD_SWITCH_B_ONE], // R4
                    pg_mask_a_q}; // R2 R3

  // A masked input passes regardless of its level.
  genvar gi;
  generate
    for (gi = 0; gi < PG_COUNT; gi++)
    begin : g_pg
      assign pg_pass[gi] = pg_mask[gi] | pg_in[gi]; // R1
    end
  endgenerate

  assign pg_all_ok = &pg_pass; // R1

  // ---------------------------------------------------------------
  // Rail outputs
  // ---------------------------------------------------------------

  // The rail runs only while both the delayed request and the gate hold.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      rail_on_q <= 1'b0;
    else
      rail_on_q <= dly.delayed & pg_all_ok; // R11
  end

  // Step select is taken from the register; software should set it only once.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      step_q <= 1'b0;
    else
      step_q <= source_step_q[`POS_STEP_SELECT]; // R5 R6
  end

  assign controlled_converter_rail_enable = rail_on_q;
  assign voltage_increment_select         = step_q;

endmodule
`default_nettype wire

// ==== core/rail_gate_defs.svh ====
// Offsets, field positions, reset values and timing figures for the rail enable gate.
`ifndef RAIL_GATE_DEFS_SVH
`define RAIL_GATE_DEFS_SVH

// Register offsets on the register port.
`define OFF_PG_MASK_A        8'h0a
`define OFF_SOURCE_AND_STEP  8'h0b
`define OFF_ENABLE_DELAYS    8'h0c
`define OFF_GATE_STATUS      8'h10

// Reset values of the registers.
`define RST_PG_MASK_A        8'h00
`define RST_SOURCE_AND_STEP  8'hc0
`define RST_ENABLE_DELAYS    8'h00

// Field positions in the source and step register.
`define POS_STEP_SELECT      5
`define POS_SOURCE_HI        4
`define POS_SOURCE_LO        2
`define POS_MASK_SWB2_REG1   1
`define POS_MASK_LOAD_SWITCH_B_ONE        0

// Field positions in the enable delay register.
`define POS_FALL_HI          5
`define POS_FALL_LO          3
`define POS_RISE_HI          2
`define POS_RISE_LO          0

// Field positions in the status register.
`define POS_ST_RAIL_ON       0
`define POS_ST_DELAYED_REQ   1
`define POS_ST_SELECTED_REQ  2
`define POS_ST_PG_OK         3
`define POS_ST_TIMING        4

// Enable source codes.
`define SRC_INPUT_ONE        3'h0
`define SRC_INPUT_TWO        3'h1
`define SRC_INPUT_FIVE       3'h2
`define SRC_INPUT_FOUR       3'h3
`define SRC_INPUT_THREE      3'h4
`define SRC_INPUTS_THREE_FOUR 3'h5
`define SRC_INPUT_SIX        3'h6
`define SRC_ALWAYS_ON        3'h7

// Delay table in milliseconds, one entry per nonzero delay code.
`define DLY_MS_CODE1         7'h02
`define DLY_MS_CODE2         7'h04
`define DLY_MS_CODE3         7'h08
`define DLY_MS_CODE4         7'h10
`define DLY_MS_CODE5         7'h18
`define DLY_MS_CODE6         7'h20
`define DLY_MS_CODE7         7'h40

// Clock period and millisecond length, both in nanoseconds.
`define CLK_PERIOD_NS        50
`define MS_PERIOD_NS         1000000
`define MS_CYCLES            (`MS_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// ==== core/rail_gate_pkg.sv ====
// Types shared by the rail enable gate modules.
package rail_gate_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [2:0] delay_code_t;
  typedef logic [6:0] delay_ms_t;

  // One-hot states of the edge delay timer.
  typedef enum logic [2:0]
  {
    TMR_STABLE    = 3'b001,
    TMR_RISE_WAIT = 3'b010,
    TMR_FALL_WAIT = 3'b100
  } timer_state_t;

endpackage

// ==== tb/ctl_pin_driver.sv ====
// Model of the system controller that drives the six control input pins.
`timescale 1ns/1ps
`default_nettype none
module ctl_pin_driver (
  input  wire logic       clk_sys,
  input  wire logic [5:0] want,
  output var  logic [5:0] pins
);
  // Pins change just after an edge, as a synchronous controller output does.
  always_ff @(posedge clk_sys)
  begin
    pins <= want;
  end
endmodule
`default_nettype wire

// ==== tb/rail_gate_asserts.sv ====
// Port-level checks for the rail enable gate.
`timescale 1ns/1ps
`default_nettype none
`include "rail_gate_defs.svh"
module rail_gate_asserts #(
  parameter int MS_CYCLES = 4
) (
  input wire logic                     clk_sys,
  input wire logic                     reset_n,
  input wire logic [7:0]               reg_addr,
  input wire rail_gate_pkg::reg_byte_t reg_wdata,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire rail_gate_pkg::reg_byte_t reg_rdata,
  input wire logic                     control_input_one,
  input wire logic                     control_input_two,
  input wire logic                     control_input_three,
  input wire logic                     control_input_four,
  input wire logic                     control_input_five,
  input wire logic                     control_input_six,
  input wire logic                     converter_rail_one_power_good,
  input wire logic                     converter_rail_three_power_good,
  input wire logic                     converter_rail_four_power_good,
  input wire logic                     converter_rail_five_power_good,
  input wire logic                     converter_rail_six_power_good,
  input wire logic                     load_switch_a_one_power_good,
  input wire logic                     aux_regulator_two_power_good,
  input wire logic                     aux_regulator_three_power_good,
  input wire logic                     load_switch_b_one_power_good,
  input wire logic                     switch_b_two_regulator_one_power_good,
  input wire logic                     controlled_converter_rail_enable,
  input wire logic                     voltage_increment_select
);
  import rail_gate_pkg::*;
  // ----------------------------------------
  // Shadow state and derived conditions
  // ----------------------------------------
  reg_byte_t mask_q, src_q, dly_q, view;
  logic      pg_ok, sel_req;
  int        hi_q, lo_q, d_rise, d_fall;

  function automatic int ms_of(input delay_code_t c);
    case (c)
      3'h1: return `DLY_MS_CODE1;
      3'h2: return `DLY_MS_CODE2;
      3'h3: return `DLY_MS_CODE3;
      3'h4: return `DLY_MS_CODE4;
      3'h5: return `DLY_MS_CODE5;
      3'h6: return `DLY_MS_CODE6;
      3'h7: return `DLY_MS_CODE7;
      default: return 0;
    endcase
  endfunction

  // Mirrors register writes so the checks know the current settings.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      mask_q <= `RST_PG_MASK_A;
      src_q  <= `RST_SOURCE_AND_STEP;
      dly_q  <= `RST_ENABLE_DELAYS;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `OFF_PG_MASK_A) mask_q <= reg_wdata;
      if (reg_addr == `OFF_SOURCE_AND_STEP) src_q <= reg_wdata;
      if (reg_addr == `OFF_ENABLE_DELAYS) dly_q <= reg_wdata;
    end
  end

  // Counts how long the selected request has held its present level.
  always_ff @(posedge clk_sys)
  begin
    hi_q <= (!reset_n || !sel_req) ? 0 : hi_q + 1;
    lo_q <= (!reset_n || sel_req) ? 0 : lo_q + 1;
  end

  // Power-good gate, request selection, delays and expected read data.
  always_comb
  begin
    pg_ok = &({switch_b_two_regulator_one_power_good, load_switch_b_one_power_good,
               aux_regulator_three_power_good, aux_regulator_two_power_good,
               load_switch_a_one_power_good, converter_rail_six_power_good,
               converter_rail_five_power_good, converter_rail_four_power_good,
               converter_rail_three_power_good, converter_rail_one_power_good}
              | {src_q[1:0], mask_q});
    case (src_q[4:2])
      `SRC_INPUT_ONE: sel_req = control_input_one;
      `SRC_INPUT_TWO: sel_req = control_input_two;
      `SRC_INPUT_FIVE: sel_req = control_input_five;
      `SRC_INPUT_FOUR: sel_req = control_input_four;
      `SRC_INPUT_THREE: sel_req = control_input_three;
      `SRC_INPUTS_THREE_FOUR: sel_req = control_input_three & control_input_four;
      `SRC_INPUT_SIX: sel_req = control_input_six;
      default: sel_req = 1'b1;
    endcase
    d_rise = ms_of(dly_q[2:0]) * MS_CYCLES;
    d_fall = ms_of(dly_q[5:3]) * MS_CYCLES;
    case (reg_addr)
      `OFF_PG_MASK_A: view = mask_q;
      `OFF_SOURCE_AND_STEP: view = src_q;
      `OFF_ENABLE_DELAYS: view = dly_q;
      default: view = 8'h00;
    endcase
  end

  AST_MASK_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rd && reg_addr == `OFF_PG_MASK_A |=> reg_rdata == $past(mask_q))
    else $error("mask register read back wrong");
  AST_CTRL_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rd && reg_addr != `OFF_GATE_STATUS |=> reg_rdata == $past(view))
    else $error("register read back wrong");
  AST_STEP_OUT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_wr && reg_addr == `OFF_SOURCE_AND_STEP ##1 (!reg_wr)[*2]
    |-> voltage_increment_select == src_q[5])
    else $error("step output does not follow its bit");
  AST_PG_GATE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !pg_ok |=> !controlled_converter_rail_enable)
    else $error("rail on with an unmasked power-good low");
  AST_RISE_ON_TIME: assert property (@(posedge clk_sys) disable iff (!reset_n)
    hi_q == 2 + d_rise && $past(pg_ok) |-> controlled_converter_rail_enable)
    else $error("rail not on after the rise delay");
  AST_RISE_NOT_EARLY: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(controlled_converter_rail_enable) |-> hi_q >= 2 + d_rise)
    else $error("rail on before the rise delay");
  AST_FALL_ON_TIME: assert property (@(posedge clk_sys) disable iff (!reset_n)
    lo_q == 2 + d_fall |-> !controlled_converter_rail_enable)
    else $error("rail still on after the fall delay");
  AST_FALL_NOT_EARLY: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(controlled_converter_rail_enable) && $past(pg_ok) |-> lo_q >= 2 + d_fall)
    else $error("rail off before the fall delay");
endmodule

bind rail_enable_gating_logic rail_gate_asserts #(.MS_CYCLES(MS_CYCLES)) chk (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the rail enable gate.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rail_gate_pkg::*;
  localparam int MS = 4;
  logic       clk_sys, reset_n, reg_wr, reg_rd, rail, step;
  logic [7:0] reg_addr, d;
  reg_byte_t  reg_wdata, reg_rdata;
  logic [5:0] want, pins, p;
  logic [9:0] pg, m;
  int         fail_count, checks_done, n, e;

  rail_enable_gating_logic #(.MS_CYCLES(MS)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .control_input_one(pins[0]), .control_input_two(pins[1]), .control_input_three(pins[2]),
    .control_input_four(pins[3]), .control_input_five(pins[4]), .control_input_six(pins[5]),
    .converter_rail_one_power_good(pg[0]), .converter_rail_three_power_good(pg[1]),
    .converter_rail_four_power_good(pg[2]), .converter_rail_five_power_good(pg[3]),
    .converter_rail_six_power_good(pg[4]), .load_switch_a_one_power_good(pg[5]),
    .aux_regulator_two_power_good(pg[6]), .aux_regulator_three_power_good(pg[7]),
    .load_switch_b_one_power_good(pg[8]), .switch_b_two_regulator_one_power_good(pg[9]),
    .controlled_converter_rail_enable(rail), .voltage_increment_select(step));
  ctl_pin_driver ctl (.clk_sys(clk_sys), .want(want), .pins(pins));

  // Free-running system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic int ms_of(input int c);
    int t[8] = '{0, 2, 4, 8, 16, 24, 32, 64};
    return t[c];
  endfunction

  function automatic logic sel_of(input int c, input logic [5:0] x);
    logic [7:0] s = {1'b1, x[5], x[2] & x[3], x[2], x[3], x[4], x[1], x[0]};
    return s[c];
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] v, input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, {8'h00, v}, {8'h00, reg_rdata});
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  // Counts cycles until the rail reaches a level, giving up after a bound.
  task automatic wait_rail(input logic lvl, input int exp, input string what);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (rail !== lvl && n < 1000);
    chk(what, exp[15:0], n[15:0]);
    if (n >= 1000)
    begin
      fail_count++;
      summarize();
    end
  endtask

  // Main sequence: reset, registers, sources, masks, delays.
  initial
  begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    want = 6'h00;
    pg = 10'h3ff;
    fail_count = 0;
    checks_done = 0;
    void'($urandom(92130));
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(8'h0a, 8'h00, "mask reset");
    rd(8'h0b, 8'hc0, "source reset");
    rd(8'h0c, 8'h00, "delay reset");
    wr(8'h33, 8'hff);
    rd(8'h33, 8'h00, "unmapped");
    chk("rail reset", 16'h0, {15'h0, rail});
    for (int i = 0; i < 9; i++)
    begin
      d = 8'($urandom);
      if (i % 3 == 1) d = d & 8'he3;
      wr(8'h0a + 8'(i % 3), d);
      rd(8'h0a + 8'(i % 3), d, "readback");
      cyc(1);
      if (i % 3 == 1) chk("step", {15'h0, d[5]}, {15'h0, step});
    end
    wr(8'h0a, 8'hff);
    wr(8'h0c, 8'h00);
    // Every source code with random and hand-picked pin patterns.
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h0b, 8'hc3 | 8'(c << 2));
      for (int k = 0; k < 8; k++)
      begin
        p = k == 0 ? 6'h00 : k == 1 ? 6'h3f : k == 2 ? 6'h04 : 6'($urandom);
        @(posedge clk_sys);
        want <= p;
        cyc(6);
        chk("source", {15'h0, sel_of(c, p)}, {15'h0, rail});
      end
    end
    // Each power-good alone, then masked, then random mixtures.
    wr(8'h0b, 8'hdf);
    for (int i = 0; i < 30; i++)
    begin
      m = i < 10 ? ~(10'h1 << i) : i < 20 ? 10'h3ff : 10'($urandom);
      p = 6'h00;
      wr(8'h0a, m[7:0]);
      wr(8'h0b, 8'hdc | {6'h00, m[9:8]});
      @(posedge clk_sys);
      pg <= i < 20 ? ~(10'h1 << (i % 10)) : 10'($urandom);
      cyc(4);
      chk("gate", {15'h0, &(pg | m)}, {15'h0, rail});
    end
    // Rise and fall delays with distinct codes, then a cancelled rise.
    wr(8'h0a, 8'hff);
    pg <= 10'h3ff;
    wr(8'h0b, 8'hc3);
    want <= 6'h00;
    cyc(8);
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h0c, {2'b00, 3'(7 - k), 3'(k)});
      @(posedge clk_sys);
      want <= 6'h01;
      wait_rail(1'b1, 3 + ms_of(k) * MS, "rise time");
      rd(8'h10, 8'h0f, "status");
      @(posedge clk_sys);
      want <= 6'h00;
      wait_rail(1'b0, 3 + ms_of(7 - k) * MS, "fall time");
      e = ms_of(k) * MS;
      if (k > 0)
      begin
        @(posedge clk_sys);
        want <= 6'h01;
        cyc(e / 2);
        @(posedge clk_sys);
        want <= 6'h00;
        cyc(e + 8);
        chk("cancelled rise", 16'h0, {15'h0, rail});
      end
    end
    summarize();
  end
endmodule
`default_nettype wire
